// [scp_cfg.svh]
/*
 * Constants of the SCSI card control block: decode codes, register
 * field positions, reset values and reset timing figures.
 * Assumes a 200 MHz clock; included by its bare name.
 */
`ifndef SCP_CFG_SVH
`define SCP_CFG_SVH

// ****************************************
// Register offsets in card space
// ****************************************
`define SCP_OFS_STATUS   32'h0334_2000
`define SCP_OFS_PAGE     32'h0334_3000
// Decode line pair {upper, lower} for each register
`define SCP_DEC_STATUS   2'h2
`define SCP_DEC_PAGE     2'h3
// Memory windows: neither register answers here
`define SCP_DEC_WINDOW   2'h1

// ****************************************
// Page register fields
// ****************************************
`define SCP_PAGE_USER_RST_BIT 7
`define SCP_PAGE_INT_EN_BIT   6
`define SCP_PAGE_W       6
`define SCP_PAGE_RST     8'h00
// Synchroniser idle: select and strobes high, all else low
`define SCP_SYNC_RST     9'h1c0

// ****************************************
// Status register fields
// ****************************************
`define SCP_ST_SCSI_BIT  4
`define SCP_ST_DMA_BIT   2
`define SCP_ST_REQ_BIT   0
`define SCP_ST_UNUSED    8'hea

// ****************************************
// Timing
// ****************************************
`define SCP_CLK_PS       5000
`define SCP_DMA_RST_NS   250
`define SCP_SCSI_RST_NS  1000
`define SCP_DMA_RST_CYC  ((`SCP_DMA_RST_NS * 1000 + `SCP_CLK_PS - 1) / `SCP_CLK_PS)
`define SCP_SCSI_RST_CYC ((`SCP_SCSI_RST_NS * 1000 + `SCP_CLK_PS - 1) / `SCP_CLK_PS)

`endif

// [scp_control.sv]
/*
 * Card-space control of a SCSI expansion card: page register,
 * interrupt status, clear strobe, internal reset and interrupt merge.
 * Assumes asynchronous host strobes held for at least three clocks,
 * with address and data stable while a strobe is low, and controller
 * pins that may be asynchronous to clk.
 */
`timescale 1ns/100ps
`include "scp_cfg.svh"

// Behaviour
// - Page register selects the EPROM window page, 8 KB to 128 KB code.
// - Top two page register bits are interrupt enable and user reset.
// - Interrupt enable resets to 0; no card interrupt until set.
// - User reset resets to 0; while 1, internal reset is driven.
// - Internal reset leaves the page register untouched.
// - In target mode the SCSI bus reset drives internal reset.
// - Internal reset reaches the SCSI controller, which reports it.
// - The same page value selects the SRAM window page.
// - Card-space accesses use a separate path from DMA traffic.
// - DMA terminal count pulse sets a sticky status flag.
// - DMA flag clears only by a write to the clear address or by system reset.
// - SCSI controller interrupt is shown live in status.
// - DMA and SCSI interrupts merge into one gated card request.
// - Write at decode 11 loads page register; read undefined.
// - Decode 10 reads status; a write there clears the DMA flag.
// - Bit 7 user reset, bit 6 interrupt enable, low bits page.
// - Status bit 4 SCSI, bit 2 DMA count, bit 0 card request.
module scp_control
  import scp_pkg::*;
#(
  parameter int PAGE_W = `SCP_PAGE_W
) (
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic              card_select_n,
  input  wire logic              read_strobe_n,
  input  wire logic              write_strobe_n,
  input  wire logic              upper_decode_line,
  input  wire logic              lower_decode_line,
  input  wire logic [7:0]        host_data_in,
  output logic      [7:0]        host_data_out,
  output logic                   host_data_oe,
  input  wire logic              terminal_count,
  input  wire logic              scsi_bus_controller_irq,
  input  wire logic              scsi_bus_reset,
  input  wire logic              target_mode,
  output logic      [PAGE_W-1:0] eprom_page,
  output logic      [PAGE_W-1:0] sram_page,
  output logic                   internal_reset,
  output logic                   card_interrupt_request
);

  // ****************************************
  // Decode
  // ****************************************
  function automatic scp_sel_type decode(input logic [1:0] lines);
    scp_sel_type s;
    s = SCP_SEL_NONE;
    if (lines == `SCP_DEC_PAGE) begin
      s = SCP_SEL_PAGE;
    end else if (lines == `SCP_DEC_STATUS) begin
      s = SCP_SEL_STATUS;
    end
    return s;
  endfunction

  // ****************************************
  // Input synchronisers
  // ****************************************
  // Data rides two flops of its own, as many as the strobes, so both settle together.
  // Bundle: cs, rd, wr, upper, lower, count, irq, busrst, target
  localparam int SYNC_W = 9;

  logic [SYNC_W-1:0] sync_q1;
  logic [SYNC_W-1:0] sync_q2;
  logic [7:0]        data_q1;
  logic [7:0]        data_q2;
  wire  [SYNC_W-1:0] raw_pins;

  assign raw_pins = {card_select_n, read_strobe_n, write_strobe_n,
                     upper_decode_line, lower_decode_line,
                     terminal_count, scsi_bus_controller_irq,
                     scsi_bus_reset, target_mode};

  always_ff @(posedge clk) begin
    if (srst) begin
      sync_q1 <= `SCP_SYNC_RST;
      sync_q2 <= `SCP_SYNC_RST;
      data_q1 <= 8'h00;
      data_q2 <= 8'h00;
    end else begin
      sync_q1 <= raw_pins;
      sync_q2 <= sync_q1;
      data_q1 <= host_data_in;
      data_q2 <= data_q1;
    end
  end

  wire       cs_n_s   = sync_q2[8];
  wire       rd_n_s   = sync_q2[7];
  wire       wr_n_s   = sync_q2[6];
  wire [1:0] lines_s  = sync_q2[5:4];
  wire       count_s  = sync_q2[3];
  wire       scsi_s   = sync_q2[2];
  wire       busrst_s = sync_q2[1];
  wire       target_s = sync_q2[0];

  // ****************************************
  // Access detection
  // ****************************************
  logic wr_act_d;
  logic count_d;

  wire         wr_act  = !cs_n_s && !wr_n_s;
  wire         rd_act  = !cs_n_s && !rd_n_s;
  wire         wr_rise = wr_act && !wr_act_d;
  scp_sel_type sel;
  assign sel = decode(lines_s);

  wire page_wr_evt = wr_rise && (sel == SCP_SEL_PAGE);
  wire clr_evt     = wr_rise && (sel == SCP_SEL_STATUS);
  wire count_evt   = count_s && !count_d;

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_act_d <= 1'b0;
      count_d  <= 1'b0;
    end else begin
      wr_act_d <= wr_act;
      count_d  <= count_s;
    end
  end

  // ****************************************
  // Page register
  // ****************************************
  // Cleared by system reset only; internal reset never touches it.
  scp_page_type page_reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      page_reg <= `SCP_PAGE_RST;
    end else if (page_wr_evt) begin
      page_reg <= data_q2;
    end
  end

  assign eprom_page = page_reg.page;
  assign sram_page  = page_reg.page;

  // ****************************************
  // Internal reset
  // ****************************************
  // Pulse length is left to software; no stretcher is built in.
  wire next_internal_reset = page_reg.user_reset
                           || (target_s && busrst_s);

  always_ff @(posedge clk) begin
    if (srst) begin
      internal_reset <= 1'b0;
    end else begin
      internal_reset <= next_internal_reset;
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  logic dma_flag;

  // Set beats clear, so a count landing on the clear write is kept.
  always_ff @(posedge clk) begin
    if (srst) begin
      dma_flag <= 1'b0;
    end else if (count_evt) begin
      dma_flag <= 1'b1;
    end else if (clr_evt) begin
      dma_flag <= 1'b0;
    end
  end

  wire next_card_irq = page_reg.interrupt_enable
                     && (dma_flag || scsi_s);

  always_ff @(posedge clk) begin
    if (srst) begin
      card_interrupt_request <= 1'b0;
    end else begin
      card_interrupt_request <= next_card_irq;
    end
  end

  // ****************************************
  // Status read path
  // ****************************************
  // Own data path: nothing here reaches the SRAM or DMA buses.
  // Status lags the live state by one clock; slow host strobes hide it.
  logic [7:0] status_value;

  always_comb begin
    status_value                   = 8'h00;
    status_value[`SCP_ST_SCSI_BIT] = scsi_s;
    status_value[`SCP_ST_DMA_BIT]  = dma_flag;
    status_value[`SCP_ST_REQ_BIT]  = card_interrupt_request;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      host_data_out <= 8'h00;
    end else begin
      host_data_out <= status_value;
    end
  end

  // Page reads stay undriven, since their data is undefined.
  assign host_data_oe = rd_act && (sel == SCP_SEL_STATUS);

  // ****************************************
  // Checks
  // ****************************************
  enable_gate_a: assert property (@(posedge clk) disable iff (srst)
    !$past(page_reg.interrupt_enable) |-> !card_interrupt_request)
    else $error("card request without interrupt enable");

  user_reset_a: assert property (@(posedge clk) disable iff (srst)
    $past(page_reg.user_reset) |-> internal_reset)
    else $error("user reset did not drive internal reset");

  page_hold_a: assert property (@(posedge clk) disable iff (srst)
    internal_reset && !page_wr_evt |=> $stable(page_reg))
    else $error("page register changed under internal reset");

  target_rst_a: assert property (@(posedge clk) disable iff (srst)
    target_s && busrst_s |=> internal_reset)
    else $error("bus reset ignored in target mode");

  no_target_a: assert property (@(posedge clk) disable iff (srst)
    !page_reg.user_reset && !target_s |=> !internal_reset)
    else $error("internal reset without cause");

  page_mirror_a: assert property (@(posedge clk) disable iff (srst)
    sram_page == eprom_page)
    else $error("sram page differs from eprom page");

  count_capture_a: assert property (@(posedge clk) disable iff (srst)
    count_evt |=> dma_flag ##1 (dma_flag || $past(clr_evt)))
    else $error("terminal count not captured");

  dma_hold_a: assert property (@(posedge clk) disable iff (srst)
    dma_flag && !clr_evt |=> dma_flag)
    else $error("dma flag dropped without clear");

  clr_action_a: assert property (@(posedge clk) disable iff (srst)
    clr_evt && !count_evt |=> !dma_flag)
    else $error("clear strobe did not clear dma flag");

  scsi_live_a: assert property (@(posedge clk) disable iff (srst)
    host_data_out[`SCP_ST_SCSI_BIT] == $past(scsi_s))
    else $error("scsi interrupt not reflected live");

  irq_merge_a: assert property (@(posedge clk) disable iff (srst)
    $rose(scsi_s) && page_reg.interrupt_enable && !page_wr_evt
      |=> card_interrupt_request ##1 host_data_out[`SCP_ST_REQ_BIT])
    else $error("scsi interrupt did not raise card request");

  page_load_a: assert property (@(posedge clk) disable iff (srst)
    page_wr_evt |=> page_reg == $past(data_q2) ##1 eprom_page == $past(data_q2[5:0], 2))
    else $error("page register load wrong");

  unused_zero_a: assert property (@(posedge clk) disable iff (srst)
    (host_data_out & `SCP_ST_UNUSED) == 8'h00)
    else $error("unused status bits not zero");

  path_iso_a: assert property (@(posedge clk) disable iff (srst)
    host_data_oe |-> rd_act && sel == SCP_SEL_STATUS && !wr_act)
    else $error("data driven outside status read");

  // ****************************************
  // Checks: status byte and read path
  // ****************************************
  // One clock of lag: each bit shows the state of the clock before.
  status_dma_a: assert property (@(posedge clk) disable iff (srst)
    host_data_out[`SCP_ST_DMA_BIT] == $past(dma_flag))
    else $error("dma flag not shown in status");

  status_req_a: assert property (@(posedge clk) disable iff (srst)
    host_data_out[`SCP_ST_REQ_BIT] == $past(card_interrupt_request))
    else $error("card request not shown in status");

  page_read_a: assert property (@(posedge clk) disable iff (srst)
    rd_act && sel == SCP_SEL_PAGE |-> !host_data_oe)
    else $error("page read drove the data bus");

  status_read_a: assert property (@(posedge clk) disable iff (srst)
    rd_act && sel == SCP_SEL_STATUS |-> host_data_oe)
    else $error("status read left the data bus idle");

  // ****************************************
  // Checks: page register
  // ****************************************
  reset_clear_a: assert property (@(posedge clk)
    srst |=> page_reg == `SCP_PAGE_RST && !internal_reset && !dma_flag
             && !card_interrupt_request)
    else $error("system reset left state behind");

  page_fields_a: assert property (@(posedge clk) disable iff (srst)
    page_wr_evt |=> page_reg.user_reset == $past(data_q2[`SCP_PAGE_USER_RST_BIT])
                 && page_reg.interrupt_enable == $past(data_q2[`SCP_PAGE_INT_EN_BIT]))
    else $error("page control bits in wrong place");

  page_change_a: assert property (@(posedge clk) disable iff (srst)
    $changed(page_reg) |-> $past(page_wr_evt) || $past(srst))
    else $error("page register changed without a page write");

  clr_page_a: assert property (@(posedge clk) disable iff (srst)
    clr_evt |=> $stable(page_reg))
    else $error("clear strobe touched the page register");

  // ****************************************
  // Checks: interrupt flag and merge
  // ****************************************
  clear_only_a: assert property (@(posedge clk) disable iff (srst)
    $fell(dma_flag) |-> $past(clr_evt) || $past(srst))
    else $error("dma flag cleared without clear strobe");

  page_dma_a: assert property (@(posedge clk) disable iff (srst)
    page_wr_evt && dma_flag |=> dma_flag)
    else $error("page write cleared the dma flag");

  enable_next_a: assert property (@(posedge clk) disable iff (srst)
    !page_reg.interrupt_enable |=> !card_interrupt_request)
    else $error("card request while interrupts disabled");

  dma_irq_a: assert property (@(posedge clk) disable iff (srst)
    dma_flag && page_reg.interrupt_enable |=> card_interrupt_request)
    else $error("dma flag did not raise card request");

  scsi_irq_a: assert property (@(posedge clk) disable iff (srst)
    scsi_s && page_reg.interrupt_enable |=> card_interrupt_request)
    else $error("scsi interrupt did not hold card request");

  irq_drop_a: assert property (@(posedge clk) disable iff (srst)
    !dma_flag && !scsi_s |=> !card_interrupt_request)
    else $error("card request without a source");

endmodule

// [scp_host_model.sv]
/*
 * Host processor model for the card-space control block: drives the
 * select, strobe, decode and data pins and samples the status byte.
 * Assumes the testbench calls access() and that clk is the block clock.
 */
`timescale 1ns/100ps

module scp_host_model (
  input  wire logic       clk,
  output logic            card_select_n,
  output logic            read_strobe_n,
  output logic            write_strobe_n,
  output logic            upper_decode_line,
  output logic            lower_decode_line,
  output logic [7:0]      host_data_in,
  input  wire logic [7:0] host_data_out,
  input  wire logic       host_data_oe
);
  initial begin
    card_select_n = 1'b1;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    {upper_decode_line, lower_decode_line} = 2'h0;
    host_data_in = 8'h00;
  end

  // Strobe low 4 clk, high 4 clk: the synchronisers need 3 of each
  task automatic access(input logic wr, input logic [1:0] dec, input logic [7:0] d,
                        output logic [7:0] q, output logic oe);
    @(negedge clk);
    card_select_n = 1'b0;
    read_strobe_n = wr;
    write_strobe_n = !wr;
    {upper_decode_line, lower_decode_line} = dec;
    host_data_in = d;
    repeat (4) @(negedge clk);
    q = host_data_out;
    oe = host_data_oe;
    card_select_n = 1'b1;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    // Released lines show the inverse, never the stale value
    {upper_decode_line, lower_decode_line} = ~dec;
    host_data_in = ~d;
    repeat (4) @(negedge clk);
  endtask
endmodule

// [scp_pkg.sv]
/*
 * Types of the SCSI card control block.
 * Assumes scp_cfg.svh is on the include path.
 */
`include "scp_cfg.svh"

package scp_pkg;

  typedef struct packed {
    logic                   user_reset;
    logic                   interrupt_enable;
    logic [`SCP_PAGE_W-1:0] page;
  } scp_page_type;

  typedef enum logic [1:0] {
    SCP_SEL_NONE   = 2'b00,
    SCP_SEL_STATUS = 2'b01,
    SCP_SEL_PAGE   = 2'b10
  } scp_sel_type;

endpackage

// [tb_top.sv]
/*
 * Self-checking testbench of the card-space control block.
 * Assumes scp_cfg.svh on the include path and the host model beside it.
 */
`timescale 1ns/100ps
`include "scp_cfg.svh"

module tb_top;
  logic       clk, srst, terminal_count, scsi_bus_controller_irq;
  logic       scsi_bus_reset, target_mode;
  wire        cs_n, rd_n, wr_n, up, lo, oe_w, ireset, irq;
  wire  [7:0] din, dout;
  wire  [5:0] eprom_page, sram_page;
  int         error_cnt = 0;
  int         check_count = 0;
  logic [7:0] q;
  logic       oe;

  scp_control scp_control_inst (.clk(clk), .srst(srst), .card_select_n(cs_n),
    .read_strobe_n(rd_n), .write_strobe_n(wr_n), .upper_decode_line(up),
    .lower_decode_line(lo), .host_data_in(din), .host_data_out(dout),
    .host_data_oe(oe_w), .terminal_count(terminal_count),
    .scsi_bus_controller_irq(scsi_bus_controller_irq), .scsi_bus_reset(scsi_bus_reset),
    .target_mode(target_mode), .eprom_page(eprom_page), .sram_page(sram_page),
    .internal_reset(ireset), .card_interrupt_request(irq));

  scp_host_model scp_host_model_inst (.clk(clk), .card_select_n(cs_n),
    .read_strobe_n(rd_n), .write_strobe_n(wr_n), .upper_decode_line(up),
    .lower_decode_line(lo), .host_data_in(din), .host_data_out(dout),
    .host_data_oe(oe_w));

  // ****************
  // Shared tasks
  // ****************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [1:0] dec, input logic [7:0] d);
    scp_host_model_inst.access(1'b1, dec, d, q, oe);
  endtask

  task automatic rd(input logic [1:0] dec);
    scp_host_model_inst.access(1'b0, dec, 8'h00, q, oe);
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ****************
  // Scenarios
  // ****************
  task automatic t_reset;
    chk({2'h0, eprom_page}, 8'h00);
    chk({7'h0, ireset}, 8'h00);
    rd(`SCP_DEC_STATUS);
    chk({7'h0, oe}, 8'h01);
    chk(q, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_page;
    wr(`SCP_DEC_PAGE, 8'h85);
    chk({2'h0, eprom_page}, 8'h05);
    chk({2'h0, sram_page}, 8'h05);
    chk({7'h0, ireset}, 8'h01);
    chk({7'h0, irq}, 8'h00);
    // Host keeps the reset up for the slower controller
    repeat (`SCP_SCSI_RST_CYC) @(negedge clk);
    chk({2'h0, eprom_page}, 8'h05);
    wr(`SCP_DEC_PAGE, 8'h3f);
    chk({2'h0, eprom_page}, 8'h3f);
    chk({7'h0, ireset}, 8'h00);
    rd(`SCP_DEC_PAGE);
    chk({7'h0, oe}, 8'h00);
    $display("test page done");
  endtask

  task automatic t_dma;
    terminal_count = 1'b1;
    repeat (2) @(negedge clk);
    terminal_count = 1'b0;
    repeat (4) @(negedge clk);
    chk({7'h0, irq}, 8'h00);
    rd(`SCP_DEC_STATUS);
    chk(q, 8'h04);
    wr(`SCP_DEC_PAGE, 8'h6a);
    chk({7'h0, irq}, 8'h01);
    rd(`SCP_DEC_STATUS);
    chk(q, 8'h05);
    // A write into the memory windows must touch neither register
    wr(`SCP_DEC_WINDOW, 8'hff);
    chk({7'h0, irq}, 8'h01);
    chk({2'h0, eprom_page}, 8'h2a);
    wr(`SCP_DEC_STATUS, 8'hff);
    chk({7'h0, irq}, 8'h00);
    rd(`SCP_DEC_STATUS);
    chk(q, 8'h00);
    $display("test dma done");
  endtask

  task automatic t_scsi;
    scsi_bus_controller_irq = 1'b1;
    repeat (4) @(negedge clk);
    chk({7'h0, irq}, 8'h01);
    rd(`SCP_DEC_STATUS);
    chk(q, 8'h11);
    scsi_bus_controller_irq = 1'b0;
    repeat (4) @(negedge clk);
    chk({7'h0, irq}, 8'h00);
    $display("test scsi done");
  endtask

  task automatic t_target;
    scsi_bus_reset = 1'b1;
    repeat (4) @(negedge clk);
    chk({7'h0, ireset}, 8'h00);
    target_mode = 1'b1;
    repeat (4) @(negedge clk);
    chk({7'h0, ireset}, 8'h01);
    chk({2'h0, eprom_page}, 8'h2a);
    scsi_bus_reset = 1'b0;
    repeat (4) @(negedge clk);
    chk({7'h0, ireset}, 8'h00);
    $display("test target done");
  endtask

  // ****************
  // Clock, run, watchdog
  // ****************
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    srst = 1'b1;
    terminal_count = 1'b0;
    scsi_bus_controller_irq = 1'b0;
    scsi_bus_reset = 1'b0;
    target_mode = 1'b0;
    repeat (16) @(negedge clk);
    srst = 1'b0;
    t_reset;
    t_page;
    t_dma;
    t_scsi;
    t_target;
    end_sim;
  end

  // Whole run is well under 1000 clocks
  initial begin
    #20000;
    error_cnt++;
    end_sim;
  end
endmodule
